// ---- rtl/cfg_slice_pkg.sv ----
// Function
// RL1: Index 14h reads zero, stores nothing
// RL2: Shadow reachable only in config state, index 15h
// RL3: Shadow mirrors last run-time FIFO control write
// RL4: Bit 0 enables both transmit and receive FIFOs
// RL5: Bit 1 flushes receive FIFO, self-clears
// RL6: Bit 2 flushes transmit FIFO, self-clears
// RL7: Bit 3 stored, no effect on UART
// RL8: Bits 7:6 pick trigger 1/4/8/14 bytes
// RL9: Indices 16h to 20h read zero
// RL10: Select zero: clear timeout on status read end
// RL11: Select one: clear timeout on write of one
// RL12: Index 22h: DMA 2:0, IRQ 5:3, 7:6 zero
// RL13: ECP indicators are storage only
// RL14: ECP indicators reset on power-on and hard reset
// RL15: No EPP: 4-byte base, bits 1:0 ignored
// RL16: EPP: 8-byte base, bits 2:0 ignored
// RL17: Base bits nine and eight zero disable decode
// RL18: Non-ECP modes need address bits 15:10 zero
// RL19: ECP mode lets address bit 10 be set
// RL20: Index 23h holds base bits 9:2, reset zero
// RL21: Access only in config state via index
// RL22: Reserved bits ignore writes, read zero
//
// Package of constants and carriers for the configuration slice 14h..23h.
// Assumes the configuration port sequencing lives outside and delivers strobes.
package cfg_slice_pkg;

   // Configuration indices
   localparam logic [7:0] IDX_RSVD_A     = 8'h14;
   localparam logic [7:0] IDX_FIFO_SHAD  = 8'h15;
   localparam logic [7:0] IDX_RSVD_B_LO  = 8'h16;
   localparam logic [7:0] IDX_RSVD_B_HI  = 8'h20;
   localparam logic [7:0] IDX_EPP_TO_SEL = 8'h21;
   localparam logic [7:0] IDX_ECP_IND    = 8'h22;
   localparam logic [7:0] IDX_LPT_BASE   = 8'h23;

   // Writable-bit masks (reserved bits read zero)
   localparam logic [7:0] FIFO_SHAD_MASK = 8'hC9;
   localparam logic [7:0] EPP_TO_MASK    = 8'h04;
   localparam logic [7:0] ECP_IND_MASK   = 8'h3F;

   // Field positions in the FIFO control value
   localparam int FCR_FIFO_EN  = 0;
   localparam int FCR_RX_FLUSH = 1;
   localparam int FCR_TX_FLUSH = 2;
   localparam int FCR_DMA_MODE = 3;
   localparam int FCR_TRIG_LO  = 6;

   // Field positions elsewhere
   localparam int TO_SEL_BIT    = 2;
   localparam int ECP_DMA_LO    = 0;
   localparam int ECP_IRQ_LO    = 3;
   localparam int EPP_TO_STAT_BIT = 0;

   // Reset values
   localparam logic [7:0] FIFO_SHAD_RST = 8'h00;
   localparam logic [7:0] EPP_TO_RST    = 8'h00;
   localparam logic [7:0] ECP_IND_RST   = 8'h00;
   localparam logic [7:0] LPT_BASE_RST  = 8'h00;

   // Receive trigger levels in bytes
   localparam logic [4:0] TRIG_LVL0 = 5'h01;
   localparam logic [4:0] TRIG_LVL1 = 5'h04;
   localparam logic [4:0] TRIG_LVL2 = 5'h08;
   localparam logic [4:0] TRIG_LVL3 = 5'h0E;

   // Configuration-port access carrier
   typedef struct packed {
      logic       cfgActive;  // Configuration state active
      logic [7:0] index;      // Value of config_index_reg
      logic       wr;         // One-cycle data port write
      logic       rd;         // One-cycle data port read
      logic [7:0] wdata;      // Write data
   } cfg_access_t;

   // UART-facing FIFO controls
   typedef struct packed {
      logic       fifoEnable;  // Both FIFOs enabled
      logic       rxFlush;     // One-cycle receive flush
      logic       txFlush;     // One-cycle transmit flush
      logic       dmaMode;     // Stored only
      logic [4:0] rxTrigger;   // Trigger level in bytes
   } uart_fifo_ctl_t;

endpackage : cfg_slice_pkg

// ---- rtl/uart_lpt_config_regs.sv ----
// Configuration slice 14h..23h: FIFO control shadow, EPP timeout clear
// method, ECP software indicators and parallel port base decode.
// Assumes synchronous one-cycle strobes on mclk from the config port logic
// and from the UART / parallel port cores.
`timescale 1ns/1ns
module uart_lpt_config_regs (
   // Clock and reset
   input  wire logic                         mclk,
   input  wire logic                         rst_b,
   input  wire logic                         hardRst,
   // Configuration data port
   input  wire cfg_slice_pkg::cfg_access_t   cfgAcc,
   output logic [7:0]                        cfgRdata,
   output logic                              cfgHit,
   // Run-time write of fifo_control_reg from the UART
   input  wire logic                         fcrWrite,
   input  wire logic [7:0]                   fcrWdata,
   output cfg_slice_pkg::uart_fifo_ctl_t     fifoCtl,
   // EPP timeout status
   input  wire logic                         eppTimeoutEvent,
   input  wire logic                         eppStatusReadEnd,
   input  wire logic                         eppStatusWrite,
   input  wire logic [7:0]                   eppStatusWdata,
   output logic                              eppTimeoutFlag,
   // ECP software indicators
   output logic [2:0]                        ecpDmaInd,
   output logic [2:0]                        ecpIrqInd,
   // Parallel port address decode
   input  wire logic [15:0]                  hostAddr,
   input  wire logic                         eppEnabled,
   input  wire logic                         ecpMode,
   output logic                              lptSelect
);

   // Register storage
   logic [7:0] fifoShadow_r;  // Shadow of fifo_control_reg
   logic [7:0] eppToSel_r;    // Timeout clear select
   logic [7:0] ecpInd_r;      // ECP indicators
   logic [7:0] lptBase_r;     // Base address bits 9:2
   logic       eppTo_r;       // EPP timeout flag

   // Decoded config write and read strobes
   logic       cfgWr;
   logic       cfgRd;

   // Data port active only in config state
   assign cfgWr = cfgAcc.cfgActive & cfgAcc.wr; // RL21
   assign cfgRd = cfgAcc.cfgActive & cfgAcc.rd; // RL21

   // Decode trigger code into a byte count
   function automatic logic [4:0] trigBytes(input logic [1:0] code);
      case (code)
         2'b00:   trigBytes = cfg_slice_pkg::TRIG_LVL0;
         2'b01:   trigBytes = cfg_slice_pkg::TRIG_LVL1;
         2'b10:   trigBytes = cfg_slice_pkg::TRIG_LVL2;
         default: trigBytes = cfg_slice_pkg::TRIG_LVL3;
      endcase
   endfunction : trigBytes

   // Shadow: either write path updates it; flush bits never stored
   // so they read back zero, which is how they self-clear.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fifoShadow_r <= cfg_slice_pkg::FIFO_SHAD_RST;
      end else if (fcrWrite) begin
         // Run-time write wins over a config write in the same cycle
         fifoShadow_r <= fcrWdata & cfg_slice_pkg::FIFO_SHAD_MASK; // RL3
      end else if (cfgWr && cfgAcc.index == cfg_slice_pkg::IDX_FIFO_SHAD) begin
         fifoShadow_r <= cfgAcc.wdata & cfg_slice_pkg::FIFO_SHAD_MASK; // RL2
      end
   end

   // FIFO controls toward the UART, registered
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         fifoCtl <= '{fifoEnable: 1'b0, rxFlush: 1'b0, txFlush: 1'b0,
                      dmaMode: 1'b0, rxTrigger: cfg_slice_pkg::TRIG_LVL0};
      end else begin
         fifoCtl.fifoEnable <= fifoShadow_r[cfg_slice_pkg::FCR_FIFO_EN]; // RL4
         // Flush is a single pulse per write carrying a one
         fifoCtl.rxFlush <= fcrWrite & fcrWdata[cfg_slice_pkg::FCR_RX_FLUSH]; // RL5
         fifoCtl.txFlush <= fcrWrite & fcrWdata[cfg_slice_pkg::FCR_TX_FLUSH]; // RL6
         // Exported for visibility only; the UART ignores it
         fifoCtl.dmaMode <= fifoShadow_r[cfg_slice_pkg::FCR_DMA_MODE]; // RL7
         fifoCtl.rxTrigger <= trigBytes(fifoShadow_r[cfg_slice_pkg::FCR_TRIG_LO +: 2]); // RL8
      end
   end

   // EPP timeout clear select register
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         eppToSel_r <= cfg_slice_pkg::EPP_TO_RST;
      end else if (cfgWr && cfgAcc.index == cfg_slice_pkg::IDX_EPP_TO_SEL) begin
         eppToSel_r <= cfgAcc.wdata & cfg_slice_pkg::EPP_TO_MASK; // RL22
      end
   end

   // EPP timeout flag: a new timeout beats a clear in the same cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         eppTo_r <= 1'b0;
      end else if (eppTimeoutEvent) begin
         eppTo_r <= 1'b1;
      end else if (!eppToSel_r[cfg_slice_pkg::TO_SEL_BIT] && eppStatusReadEnd) begin
         eppTo_r <= 1'b0; // RL10
      end else if (eppToSel_r[cfg_slice_pkg::TO_SEL_BIT] && eppStatusWrite &&
                   eppStatusWdata[cfg_slice_pkg::EPP_TO_STAT_BIT]) begin
         eppTo_r <= 1'b0; // RL11
      end
   end

   // ECP indicators: cleared by power-on or hard reset
   always_ff @(posedge mclk) begin
      if (!rst_b || hardRst) begin
         ecpInd_r <= cfg_slice_pkg::ECP_IND_RST; // RL14
      end else if (cfgWr && cfgAcc.index == cfg_slice_pkg::IDX_ECP_IND) begin
         ecpInd_r <= cfgAcc.wdata & cfg_slice_pkg::ECP_IND_MASK; // RL12
      end
   end

   // Parallel port base address
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         lptBase_r <= cfg_slice_pkg::LPT_BASE_RST; // RL20
      end else if (cfgWr && cfgAcc.index == cfg_slice_pkg::IDX_LPT_BASE) begin
         lptBase_r <= cfgAcc.wdata; // RL20
      end
   end

   // Parallel port decode, registered one cycle after the address.
   // The base register holds address bits 9:2; with EPP the low base bit
   // is a don't-care so the window grows to eight bytes. A10 is only let
   // through in ECP mode, where the extended register block sits 400h up.
   // A base with bits 9:8 both zero turns the decoder off entirely, which
   // is also the reset state, so the port stays silent until configured.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         lptSelect <= 1'b0;
      end else begin
         lptSelect <= (lptBase_r[7:6] != 2'b00) // RL17
                    && (hostAddr[15:11] == 5'h00)
                    && (!hostAddr[10] || ecpMode) // RL18 RL19
                    && (hostAddr[9:3] == lptBase_r[7:1])
                    && (eppEnabled || hostAddr[2] == lptBase_r[0]); // RL15 RL16
      end
   end

   // Config read data; unlisted or reserved indices read zero
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cfgRdata <= 8'h00;
         cfgHit   <= 1'b0;
      end else begin
         cfgHit <= cfgRd && cfgAcc.index >= cfg_slice_pkg::IDX_RSVD_A
                         && cfgAcc.index <= cfg_slice_pkg::IDX_LPT_BASE;
         if (cfgRd) begin
            case (cfgAcc.index)
               cfg_slice_pkg::IDX_FIFO_SHAD:  cfgRdata <= fifoShadow_r; // RL2
               cfg_slice_pkg::IDX_EPP_TO_SEL: cfgRdata <= eppToSel_r;
               cfg_slice_pkg::IDX_ECP_IND:    cfgRdata <= ecpInd_r; // RL12
               cfg_slice_pkg::IDX_LPT_BASE:   cfgRdata <= lptBase_r;
               default:                       cfgRdata <= 8'h00; // RL1 RL9
            endcase
         end
      end
   end

   // Indicator outputs drive nothing in hardware routing
   assign ecpDmaInd      = ecpInd_r[cfg_slice_pkg::ECP_DMA_LO +: 3]; // RL13
   assign ecpIrqInd      = ecpInd_r[cfg_slice_pkg::ECP_IRQ_LO +: 3]; // RL13
   assign eppTimeoutFlag = eppTo_r;

endmodule : uart_lpt_config_regs

// ---- tb/uart_lpt_config_regs_checker.sv ----
// Port checker for the config slice: read answers, FIFO controls, ECP clear, EPP flag.
// Assumes a bind from the bench top with every port named.
`timescale 1ns/1ns
module uart_lpt_config_regs_checker (
   // Clock, reset and config access
   input wire logic                          mclk,
   input wire logic                          rst_b,
   input wire logic                          hardRst,
   input wire cfg_slice_pkg::cfg_access_t    cfgAcc,
   input wire logic [7:0]                    cfgRdata,
   input wire logic                          cfgHit,
   // UART, ECP and EPP side
   input wire logic                          fcrWrite,
   input wire logic [7:0]                    fcrWdata,
   input wire cfg_slice_pkg::uart_fifo_ctl_t fifoCtl,
   input wire logic                          eppTimeoutEvent,
   input wire logic                          eppTimeoutFlag,
   input wire logic [2:0]                    ecpDmaInd
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);
   // A data port read that the block must take
   wire logic rdOn = cfgAcc.cfgActive && cfgAcc.rd;
   read_hit_a: assert property (rdOn && cfgAcc.index inside {[8'h14:8'h23]} |=> cfgHit)
      else $error("range read not answered");
   idle_no_hit_a: assert property (!rdOn |=> !cfgHit)
      else $error("hit without a read");
   rsvd_zero_a: assert property (rdOn && cfgAcc.index inside {8'h14,[8'h16:8'h20]} |=> cfgRdata == 8'h00)
      else $error("reserved index read nonzero");
   flush_follow_a: assert property (fcrWrite |=> {fifoCtl.txFlush, fifoCtl.rxFlush} == $past(fcrWdata[2:1]))
      else $error("flush pulse does not follow write");
   // Flushes are single pulses, so nothing may remain without a new write
   flush_clear_a: assert property (!fcrWrite |=> !fifoCtl.rxFlush && !fifoCtl.txFlush)
      else $error("flush did not self clear");
   enable_follow_a: assert property (fcrWrite |-> ##2 fifoCtl.fifoEnable == $past(fcrWdata[0], 2))
      else $error("fifo enable wrong");
   trig_top_a: assert property (fcrWrite && fcrWdata[7:6] == 2'h3 |-> ##2 fifoCtl.rxTrigger == 5'h0E)
      else $error("top trigger level wrong");
   ecp_clear_a: assert property (hardRst |=> ecpDmaInd == 3'h0)
      else $error("hard reset left ECP indicator");
   timeout_set_a: assert property (eppTimeoutEvent |=> eppTimeoutFlag)
      else $error("timeout event not flagged");
   cover property (fcrWrite && fcrWdata[2:1] == 2'h3);
   cover property (hardRst);
   cover property (eppTimeoutFlag ##1 !eppTimeoutFlag);
endmodule : uart_lpt_config_regs_checker

// ---- tb/uart_lpt_config_regs_tb_top.sv ----
// Bench for the config slice: register access, FIFO control, EPP flag and decode.
// Assumes the design package is compiled first; binds the checker below.
`timescale 1ns/1ns
module uart_lpt_config_regs_tb_top;
   logic                          mclk = 1'b0, rst_b = 1'b0, hardRst = 1'b0, fcrWrite = 1'b0;
   logic                          eppTimeoutEvent = 1'b0, eppStatusReadEnd = 1'b0, eppStatusWrite = 1'b0;
   logic                          eppEnabled = 1'b0, ecpMode = 1'b0, lptSelect, cfgHit, eppTimeoutFlag;
   logic [7:0]                    fcrWdata = 8'h00, eppStatusWdata = 8'h00, cfgRdata, d, b;
   logic [15:0]                   hostAddr = 16'h0000;
   logic [2:0]                    ecpDmaInd, ecpIrqInd;
   cfg_slice_pkg::cfg_access_t    cfgAcc = '0;
   cfg_slice_pkg::uart_fifo_ctl_t fifoCtl;
   int                            seed = 85, err_total = 0, comparisons = 0;
   uart_lpt_config_regs dut (.mclk, .rst_b, .hardRst, .cfgAcc, .cfgRdata, .cfgHit, .fcrWrite, .fcrWdata,
      .fifoCtl, .eppTimeoutEvent, .eppStatusReadEnd, .eppStatusWrite, .eppStatusWdata, .eppTimeoutFlag,
      .ecpDmaInd, .ecpIrqInd, .hostAddr, .eppEnabled, .ecpMode, .lptSelect);
   always #2 mclk = ~mclk;
   // Inputs move 1 ns after the edge so the design samples settled values
   task automatic step;
      @(posedge mclk);
      #1;
   endtask : step
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // One data port access; rd is the inverse of wr, act is the config state
   task automatic acc(input logic [7:0] idx, input logic [7:0] wd, input logic wr, input logic act);
      step();
      cfgAcc = '{act, idx, wr, !wr, wd};
      step();
      cfgAcc.wr = 1'b0;
      cfgAcc.rd = 1'b0;
   endtask : acc
   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      acc(idx, 8'h00, 1'b0, 1'b1);
      chk("cfgRdata", cfgRdata, exp);
      chk("cfgHit", cfgHit, 8'h01);
   endtask : rd
   // Pulse of timeout event, status read end, status write
   task automatic epp(input logic [2:0] v);
      step();
      eppStatusWdata = 8'($random(seed)) | 8'h01;
      {eppTimeoutEvent, eppStatusReadEnd, eppStatusWrite} = v;
      step();
      {eppTimeoutEvent, eppStatusReadEnd, eppStatusWrite} = 3'h0;
   endtask : epp
   function automatic logic [4:0] trig(input logic [1:0] c);
      return c == 2'h0 ? 5'h01 : c == 2'h1 ? 5'h04 : c == 2'h2 ? 5'h08 : 5'h0E;
   endfunction : trig
   // Expected decode: base 9:2 in b, A2 ignored with EPP, A10 allowed in ECP
   function automatic logic hitExp(input logic [7:0] b, input logic [15:0] a, input logic epp, input logic ecp);
      return b[7:6] != 2'h0 && a[15:11] == 5'h00 && (ecp || !a[10]) && a[9:3] == b[7:1] && (epp || a[2] == b[0]);
   endfunction : hitExp
   task automatic stop_test;
      if (err_total == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : stop_test
   // Watchdog well past the few hundred cycles the sequence needs
   initial begin
      #60000;
      err_total++;
      stop_test();
   end
   initial begin
      repeat (3) @(posedge mclk);
      #1 rst_b = 1'b1;
      rd(8'h21, 8'h00);
      rd(8'h22, 8'h00);
      rd(8'h23, 8'h00);
      // Reserved indices swallow writes
      for (int i = 20; i <= 32; i++) begin
         if (i != 21) begin
            acc(8'(i), 8'hFF, 1'b1, 1'b1);
            rd(8'(i), 8'h00);
         end
      end
      // Run-time FIFO control writes: every trigger code, then random values
      for (int i = 0; i < 12; i++) begin
         d = (i < 4) ? {2'(i), 6'h3F} : 8'($random(seed));
         step();
         fcrWrite = 1'b1;
         fcrWdata = d;
         step();
         fcrWrite = 1'b0;
         chk("flush", {fifoCtl.txFlush, fifoCtl.rxFlush}, d[2:1]);
         step();
         chk("ctl", {fifoCtl.fifoEnable, fifoCtl.dmaMode}, {d[0], d[3]});
         chk("rxTrigger", fifoCtl.rxTrigger, trig(d[7:6]));
         rd(8'h15, d & 8'hC9);
      end
      // Config-side write to the shadow is stored and masked, and must not flush
      d = 8'($random(seed)) | 8'h06;
      acc(8'h15, d, 1'b1, 1'b1);
      chk("cfg flush", {fifoCtl.txFlush, fifoCtl.rxFlush}, 8'h00);
      rd(8'h15, d & 8'hC9);
      // Access outside the config state is ignored
      acc(8'h23, 8'hA5, 1'b1, 1'b1);
      acc(8'h23, 8'h5A, 1'b1, 1'b0);
      acc(8'h23, 8'h00, 1'b0, 1'b0);
      chk("cfgHit idle", cfgHit, 8'h00);
      rd(8'h23, 8'hA5);
      d = 8'($random(seed)) | 8'hC0;
      acc(8'h22, d, 1'b1, 1'b1);
      rd(8'h22, d & 8'h3F);
      chk("ecpInd", {ecpIrqInd, ecpDmaInd}, d[5:0]);
      step();
      hardRst = 1'b1;
      step();
      hardRst = 1'b0;
      rd(8'h22, 8'h00);
      // Each clear method: the other method must leave the flag set
      for (int s = 0; s < 2; s++) begin
         acc(8'h21, s ? 8'hFF : 8'h00, 1'b1, 1'b1);
         rd(8'h21, s ? 8'h04 : 8'h00);
         epp(3'h4);
         epp(s ? 3'h2 : 3'h1);
         chk("flag kept", eppTimeoutFlag, 8'h01);
         epp(s ? 3'h1 : 3'h2);
         chk("flag cleared", eppTimeoutFlag, 8'h00);
         // A new timeout in the same cycle as a clear must win
         epp(s ? 3'h5 : 3'h6);
         chk("set wins", eppTimeoutFlag, 8'h01);
         epp(s ? 3'h1 : 3'h2);
         chk("flag recleared", eppTimeoutFlag, 8'h00);
      end
      for (int i = 0; i < 80; i++) begin
         b = 8'($random(seed));
         acc(8'h23, b, 1'b1, 1'b1);
         hostAddr = 16'($random(seed));
         if (hostAddr[15]) hostAddr = {5'h00, hostAddr[10], b[7:1], hostAddr[2:0]};
         {eppEnabled, ecpMode} = 2'($random(seed));
         step();
         chk("lptSelect", lptSelect, hitExp(b, hostAddr, eppEnabled, ecpMode));
      end
      stop_test();
   end
endmodule : uart_lpt_config_regs_tb_top
bind uart_lpt_config_regs uart_lpt_config_regs_checker chk_i (.mclk, .rst_b, .hardRst, .cfgAcc, .cfgRdata,
   .cfgHit, .fcrWrite, .fcrWdata, .fifoCtl, .eppTimeoutEvent, .eppTimeoutFlag, .ecpDmaInd);
